// [src/rtc_pkg.sv]
package rtc_pkg;
  // timing
  localparam int CORE_HZ = 25_000_000;
  localparam int XTAL_HZ = 32_768;
  localparam int HALT_US = 100;
  // watchdog for a missing timebase edge, least time rounded down
  localparam int HALT_CYC = (CORE_HZ / 1_000_000 * HALT_US);
  localparam logic [14:0] PRE_LAST = 15'(XTAL_HZ - 1);
  localparam logic [14:0] PRE_HALF = 15'(XTAL_HZ / 2 - 1);

  // register addresses (byte index over the serial port)
  localparam logic [3:0] A_SEC = 4'h0;
  localparam logic [3:0] A_MIN = 4'h1;
  localparam logic [3:0] A_HOUR = 4'h2;
  localparam logic [3:0] A_WDAY = 4'h3;
  localparam logic [3:0] A_DAY = 4'h4;
  localparam logic [3:0] A_MON = 4'h5;
  localparam logic [3:0] A_YEAR = 4'h6;
  localparam logic [3:0] A_TRIM = 4'h7;
  localparam logic [3:0] A_AWMIN = 4'h8;
  localparam logic [3:0] A_AWHOUR = 4'h9;
  localparam logic [3:0] A_AWDAYS = 4'hA;
  localparam logic [3:0] A_ADMIN = 4'hB;
  localparam logic [3:0] A_ADHOUR = 4'hC;
  localparam logic [3:0] A_SPARE = 4'hD;
  localparam logic [3:0] A_CTRL1 = 4'hE;
  localparam logic [3:0] A_CTRL2 = 4'hF;

  // control 1 fields
  localparam int C1_AW_EN = 7;
  localparam int C1_AD_EN = 6;
  localparam int C1_H24 = 5;
  localparam int C1_SCK_OFF = 4;
  localparam int C1_PHALT = 3;
  localparam int C1_PSEL = 0;

  // control 2 fields
  localparam int C2_VSEL = 7;
  localparam int C2_VDET = 6;
  localparam int C2_PON = 5;
  localparam int C2_XSTOP = 4;
  localparam int C2_PFLG = 2;
  localparam int C2_WFLG = 1;
  localparam int C2_DFLG = 0;

  // periodic interrupt selections
  localparam logic [2:0] P_OFF = 3'h0;
  localparam logic [2:0] P_HALF = 3'h1;
  localparam logic [2:0] P_SEC = 3'h2;
  localparam logic [2:0] P_MIN = 3'h3;
  localparam logic [2:0] P_HOUR = 3'h4;
  localparam logic [2:0] P_DAY = 3'h5;
  localparam logic [2:0] P_MON = 3'h6;

  // reset values
  localparam logic [7:0] R_CTRL1 = 8'h20;
  localparam logic [7:0] R_ONE = 8'h01;
  localparam logic [7:0] R_ZERO = 8'h00;

  typedef logic [15:0][7:0] img_t;
endpackage : rtc_pkg

// [src/rtc_serial_link.sv]
module rtc_serial_link
  import rtc_pkg::*;
(
  input wire logic link_sclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic si_i,
  input wire img_t img_i,
  output logic so_o,
  output logic wr_tgl_o,
  output logic [3:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  logic [2:0] bit_cnt_r;
  logic cmd_done_r;
  logic rd_r;
  logic [3:0] addr_r;
  logic [6:0] sh_r;
  logic [7:0] osh_r;
  logic [7:0] rbyte;
  logic byte_end;

  assign byte_end = (bit_cnt_r == 3'h7);
  // next read byte: addressed by the command, or the one after
  assign rbyte = cmd_done_r ? img_i[4'(addr_r + 4'h1)] : img_i[sh_r[6:3]];

  // frame state ends with chip enable itself; no edge after the frame
  always_ff @(posedge link_sclk_i or negedge ce_i)
  begin
    if (!ce_i)
    begin
      bit_cnt_r <= 3'h0;
      cmd_done_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 4'h0;
      sh_r <= 7'h00;
      osh_r <= 8'h00;
      so_o <= 1'b0;
    end
    else
    begin
      sh_r <= {sh_r[5:0], si_i};
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      so_o <= osh_r[7];
      osh_r <= {osh_r[6:0], 1'b0};
      if (byte_end)
      begin
        if (!cmd_done_r)
        begin
          cmd_done_r <= 1'b1;
          addr_r <= sh_r[6:3];
          rd_r <= sh_r[2];
        end
        else
        begin
          addr_r <= 4'(addr_r + 4'h1);
        end
        if (!cmd_done_r ? sh_r[2] : rd_r)
        begin
          so_o <= rbyte[7];
          osh_r <= {rbyte[6:0], 1'b0};
        end
      end
    end
  end

  // write handoff persists across frames, so only reset clears it
  always_ff @(posedge link_sclk_i or posedge srst_i)
  begin
    if (srst_i)
    begin
      wr_tgl_o <= 1'b0;
      wr_addr_o <= 4'h0;
      wr_data_o <= 8'h00;
    end
    else if (ce_i && byte_end && cmd_done_r && !rd_r)
    begin
      wr_addr_o <= addr_r;
      wr_data_o <= {sh_r, si_i};
      wr_tgl_o <= ~wr_tgl_o;
    end
  end
endmodule : rtc_serial_link

// [src/rtc_core.sv]
// Behaviour
// - all timekeeping comes from the 32.768 kHz timebase
// - seconds to year counters all held in BCD
// - leap years add February 29 up to 2099
// - hours run in 12-hour or 24-hour format by software choice
// - six periodic interrupt periods, half second to one month
// - periodic interrupt sets a readable flag and has a halt control
// - two independent alarms interrupt when time reaches preset value
// - weekly alarm matches weekday, hour, minute; daily only hour, minute
// - all three interrupts share one active-low interrupt output
// - interrupt output is released after power-up
// - subclock output gives timebase pulses, enabled after power-up
// - serial transfers happen only while chip enable is high
// - host clocks data in and out on the serial shift clock
// - power-on flag marks a cold start
// - oscillation-halt flag marks a stopped timebase
// - supply flag latches below the software-selected threshold
// - software trim corrects the timekeeping rate
module rtc_core
  import rtc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic xtal_i,
  input wire logic vdd_below_hi_i,
  input wire logic vdd_below_lo_i,
  input wire logic link_sclk_i,
  input wire logic ce_i,
  input wire logic si_i,
  output logic so_o,
  output logic irq_out_n_o,
  output logic irq_out_n_oe_n_o,
  output logic subclock_out_o,
  output logic subclock_out_oe_n_o
);
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0}
                               : {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic [7:0] y);
    case (m)
      8'h02: month_len = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  function automatic logic [7:0] hour_inc(input logic [7:0] h,
                                          input logic h24);
    logic [7:0] low;
    low = bcd_inc({3'b000, h[4:0]});
    if (h24)
      hour_inc = (h == 8'h23) ? 8'h00 : bcd_inc(h);
    else if (h[4:0] == 5'h11)
      hour_inc = {2'b00, ~h[5], 5'h12};
    else if (h[4:0] == 5'h12)
      hour_inc = {2'b00, h[5], 5'h01};
    else
      hour_inc = {2'b00, h[5], low[4:0]};
  endfunction : hour_inc

  logic [7:0] sec_r, min_r, hour_r, wday_r, day_r, mon_r, year_r;
  logic [7:0] sec_nxt, min_nxt, hour_nxt, wday_nxt, day_nxt;
  logic [7:0] mon_nxt, year_nxt;
  logic [7:0] trim_r, awm_r, awh_r, aww_r, adm_r, adh_r, ctrl1_r;
  logic vsel_r, vdet_r, pon_r, xstop_r, pflg_r, wflg_r, dflg_r;
  logic xs1_r, xs2_r, xs3_r, vh1_r, vh2_r, vl1_r, vl2_r;
  logic ce1_r, ce2_r, wt1_r, wt2_r, wt3_r;
  logic [14:0] pre_r, pre_lim;
  logic [11:0] halt_cnt_r;
  logic xrise, tick, half, c_min, c_hour, c_day, c_mon, c_year;
  logic ev_half_r, ev_sec_r, ev_min_r, ev_hour_r, ev_day_r, ev_mon_r;
  logic al_chk_r, psel_hit, irq_on, wr_evt, clr2;
  logic [15:0] wsel;
  logic [7:0] ctrl2, wr_d;
  logic [3:0] wr_a;
  logic lk_tgl;
  img_t img_r, img_nxt;

  rtc_serial_link u_link (
    .link_sclk_i(link_sclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .si_i(si_i),
    .img_i(img_r),
    .so_o(so_o),
    .wr_tgl_o(lk_tgl),
    .wr_addr_o(wr_a),
    .wr_data_o(wr_d)
  );

  // pin and cross-domain synchronisers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      {xs1_r, xs2_r, xs3_r} <= 3'h0;
      {vh1_r, vh2_r, vl1_r, vl2_r} <= 4'h0;
      {ce1_r, ce2_r} <= 2'h0;
      {wt1_r, wt2_r, wt3_r} <= 3'h0;
    end
    else if (clk_en_i)
    begin
      xs1_r <= xtal_i;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
      vh1_r <= vdd_below_hi_i;
      vh2_r <= vh1_r;
      vl1_r <= vdd_below_lo_i;
      vl2_r <= vl1_r;
      ce1_r <= ce_i;
      ce2_r <= ce1_r;
      wt1_r <= lk_tgl;
      wt2_r <= wt1_r;
      wt3_r <= wt2_r;
    end
  end

  // address and data stay put for many core cycles after a toggle
  assign wr_evt = wt2_r ^ wt3_r;
  assign wsel = wr_evt ? (16'h0001 << wr_a) : 16'h0000;
  assign clr2 = wsel[A_CTRL2];

  assign xrise = xs2_r & ~xs3_r;
  // trim applies in seconds 00, 20 and 40 only
  assign pre_lim = (sec_r[3:0] == 4'h0 && !sec_r[4])
                 ? 15'(PRE_LAST - {{8{trim_r[6]}}, trim_r[6:0]})
                 : PRE_LAST;
  assign tick = xrise && (pre_r == pre_lim);
  assign half = xrise && (pre_r == PRE_HALF);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      pre_r <= 15'h0000;
    else if (clk_en_i)
    begin
      if (wsel[A_SEC])
        pre_r <= 15'h0000;
      else if (xrise)
        pre_r <= (pre_r == pre_lim) ? 15'h0000 : 15'(pre_r + 15'h0001);
    end
  end

  assign c_min = tick && (sec_r == 8'h59);
  assign c_hour = c_min && (min_r == 8'h59);
  assign c_day = c_hour &&
    (ctrl1_r[C1_H24] ? (hour_r == 8'h23) : (hour_r == 8'h31));
  assign c_mon = c_day && (day_r == month_len(mon_r, year_r));
  assign c_year = c_mon && (mon_r == 8'h12);

  always_comb
  begin
    sec_nxt = sec_r;
    min_nxt = min_r;
    hour_nxt = hour_r;
    wday_nxt = wday_r;
    day_nxt = day_r;
    mon_nxt = mon_r;
    year_nxt = year_r;
    if (tick)
      sec_nxt = (sec_r == 8'h59) ? 8'h00 : bcd_inc(sec_r);
    if (c_min)
      min_nxt = (min_r == 8'h59) ? 8'h00 : bcd_inc(min_r);
    if (c_hour)
      hour_nxt = hour_inc(hour_r, ctrl1_r[C1_H24]);
    if (c_day)
    begin
      wday_nxt = (wday_r == 8'h06) ? 8'h00 : 8'(wday_r + 8'h01);
      day_nxt = c_mon ? 8'h01 : bcd_inc(day_r);
    end
    if (c_mon)
      mon_nxt = c_year ? 8'h01 : bcd_inc(mon_r);
    if (c_year)
      year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
  end

  // a write to a counter wins over its own advance in that cycle
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sec_r <= R_ZERO;
      min_r <= R_ZERO;
      hour_r <= R_ZERO;
      wday_r <= R_ZERO;
      day_r <= R_ONE;
      mon_r <= R_ONE;
      year_r <= R_ZERO;
    end
    else if (clk_en_i)
    begin
      sec_r <= wsel[A_SEC] ? wr_d : sec_nxt;
      min_r <= wsel[A_MIN] ? wr_d : min_nxt;
      hour_r <= wsel[A_HOUR] ? wr_d : hour_nxt;
      wday_r <= wsel[A_WDAY] ? wr_d : wday_nxt;
      day_r <= wsel[A_DAY] ? wr_d : day_nxt;
      mon_r <= wsel[A_MON] ? wr_d : mon_nxt;
      year_r <= wsel[A_YEAR] ? wr_d : year_nxt;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      trim_r <= R_ZERO;
      awm_r <= R_ZERO;
      awh_r <= R_ZERO;
      aww_r <= R_ZERO;
      adm_r <= R_ZERO;
      adh_r <= R_ZERO;
      ctrl1_r <= R_CTRL1;
      vsel_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (wsel[A_TRIM])
        trim_r <= wr_d;
      if (wsel[A_AWMIN])
        awm_r <= wr_d;
      if (wsel[A_AWHOUR])
        awh_r <= wr_d;
      if (wsel[A_AWDAYS])
        aww_r <= wr_d;
      if (wsel[A_ADMIN])
        adm_r <= wr_d;
      if (wsel[A_ADHOUR])
        adh_r <= wr_d;
      if (wsel[A_CTRL1])
        ctrl1_r <= wr_d;
      if (clr2)
        vsel_r <= wr_d[C2_VSEL];
    end
  end

  // one-cycle events, registered so they line up with the new time
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      {ev_half_r, ev_sec_r, ev_min_r} <= 3'h0;
      {ev_hour_r, ev_day_r, ev_mon_r, al_chk_r} <= 4'h0;
    end
    else if (clk_en_i)
    begin
      ev_half_r <= half;
      ev_sec_r <= tick;
      ev_min_r <= c_min;
      ev_hour_r <= c_hour;
      ev_day_r <= c_day;
      ev_mon_r <= c_mon;
      al_chk_r <= c_min;
    end
  end

  always_comb
  begin
    case (ctrl1_r[C1_PSEL +: 3])
      P_HALF: psel_hit = ev_half_r | ev_sec_r;
      P_SEC: psel_hit = ev_sec_r;
      P_MIN: psel_hit = ev_min_r;
      P_HOUR: psel_hit = ev_hour_r;
      P_DAY: psel_hit = ev_day_r;
      P_MON: psel_hit = ev_mon_r;
      P_OFF: psel_hit = 1'b0;
      default: psel_hit = 1'b0;
    endcase
  end

  // event flags: a set in the clearing cycle survives the clear
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pflg_r <= 1'b0;
      wflg_r <= 1'b0;
      dflg_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pflg_r <= (psel_hit && !ctrl1_r[C1_PHALT])
              | (pflg_r & ~(clr2 & ~wr_d[C2_PFLG]));
      wflg_r <= (al_chk_r && ctrl1_r[C1_AW_EN] && aww_r[wday_r[2:0]]
                 && min_r == awm_r && hour_r == awh_r)
              | (wflg_r & ~(clr2 & ~wr_d[C2_WFLG]));
      dflg_r <= (al_chk_r && ctrl1_r[C1_AD_EN]
                 && min_r == adm_r && hour_r == adh_r)
              | (dflg_r & ~(clr2 & ~wr_d[C2_DFLG]));
    end
  end

  // health flags: power-on, stopped timebase, supply drop
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pon_r <= 1'b1;
      xstop_r <= 1'b0;
      vdet_r <= 1'b0;
      halt_cnt_r <= 12'h000;
    end
    else if (clk_en_i)
    begin
      pon_r <= pon_r & ~(clr2 & ~wr_d[C2_PON]);
      if (xs2_r != xs3_r)
        halt_cnt_r <= 12'h000;
      else if (halt_cnt_r != 12'(HALT_CYC))
        halt_cnt_r <= 12'(halt_cnt_r + 12'h001);
      xstop_r <= (halt_cnt_r == 12'(HALT_CYC - 1))
               | (xstop_r & ~(clr2 & ~wr_d[C2_XSTOP]));
      vdet_r <= (vsel_r ? vh2_r : vl2_r)
              | (vdet_r & ~(clr2 & ~wr_d[C2_VDET]));
    end
  end

  assign ctrl2 = {vsel_r, vdet_r, pon_r, xstop_r, 1'b0,
                  pflg_r, wflg_r, dflg_r};

  always_comb
  begin
    img_nxt = '0;
    img_nxt[A_SEC] = sec_r;
    img_nxt[A_MIN] = min_r;
    img_nxt[A_HOUR] = hour_r;
    img_nxt[A_WDAY] = wday_r;
    img_nxt[A_DAY] = day_r;
    img_nxt[A_MON] = mon_r;
    img_nxt[A_YEAR] = year_r;
    img_nxt[A_TRIM] = trim_r;
    img_nxt[A_AWMIN] = awm_r;
    img_nxt[A_AWHOUR] = awh_r;
    img_nxt[A_AWDAYS] = aww_r;
    img_nxt[A_ADMIN] = adm_r;
    img_nxt[A_ADHOUR] = adh_r;
    img_nxt[A_SPARE] = R_ZERO;
    img_nxt[A_CTRL1] = ctrl1_r;
    img_nxt[A_CTRL2] = ctrl2;
  end

  // read image is frozen during a frame so the link sees stable words
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      img_r <= '0;
    else if (clk_en_i && !ce2_r)
      img_r <= img_nxt;
  end

  assign irq_on = (pflg_r & ~ctrl1_r[C1_PHALT])
                | (wflg_r & ctrl1_r[C1_AW_EN])
                | (dflg_r & ctrl1_r[C1_AD_EN]);

  // open-drain pins: low enable means the pin is pulled low
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      irq_out_n_o <= 1'b0;
      irq_out_n_oe_n_o <= 1'b1;
      subclock_out_o <= 1'b0;
      subclock_out_oe_n_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      irq_out_n_oe_n_o <= ~irq_on;
      subclock_out_oe_n_o <= ctrl1_r[C1_SCK_OFF] | xs2_r;
    end
  end
endmodule : rtc_core

// [sim/rtc_core_assertions.sv]
module rtc_core_assertions
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic xtal_i,
  input wire logic link_sclk_i,
  input wire logic ce_i,
  input wire logic so_o,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe_n_o,
  input wire logic subclock_out_o,
  input wire logic subclock_out_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // core cycles since chip enable was last high; a release of the
  // interrupt must come from a host write, so it follows a frame closely
  logic [7:0] idle_r;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || ce_i)
      idle_r <= 8'h00;
    else if (idle_r != 8'hFF)
      idle_r <= idle_r + 8'h01;
  end

  property p_rst_irq;
    @(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> irq_out_n_oe_n_o [*4];
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("interrupt not released after reset");

  property p_rst_sck;
    @(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> ##[1:12] !subclock_out_oe_n_o;
  endproperty
  a_rst_sck: assert property (p_rst_sck)
    else $error("subclock not enabled after reset");

  property p_od_low;
    @(posedge core_clk_i) disable iff (srst_i)
    irq_out_n_o == 1'b0 && subclock_out_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain value not low");

  property p_sck_rise;
    @(posedge core_clk_i) disable iff (srst_i)
    $rose(xtal_i) |-> ##[1:5] subclock_out_oe_n_o;
  endproperty
  a_sck_rise: assert property (p_sck_rise)
    else $error("subclock missed a timebase high");

  property p_sck_pulse;
    @(posedge core_clk_i) disable iff (srst_i)
    !subclock_out_oe_n_o |-> ##[1:6] subclock_out_oe_n_o;
  endproperty
  a_sck_pulse: assert property (p_sck_pulse)
    else $error("subclock held low too long");

  property p_so_idle;
    @(posedge core_clk_i) disable iff (srst_i)
    !ce_i |-> so_o == 1'b0;
  endproperty
  a_so_idle: assert property (p_so_idle)
    else $error("serial out active while deselected");

  property p_so_stray;
    @(posedge link_sclk_i) disable iff (srst_i)
    !ce_i |=> so_o == 1'b0;
  endproperty
  a_so_stray: assert property (p_so_stray)
    else $error("serial out moved on a deselected clock");

  property p_irq_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    $fell(irq_out_n_oe_n_o) |=> !irq_out_n_oe_n_o [*8];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a host write");

  property p_irq_clr;
    @(posedge core_clk_i) disable iff (srst_i)
    $rose(irq_out_n_oe_n_o) |-> idle_r < 8'h18;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt released away from a frame");
endmodule : rtc_core_assertions

bind rtc_core rtc_core_assertions chk_u
(
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .xtal_i(xtal_i),
  .link_sclk_i(link_sclk_i),
  .ce_i(ce_i),
  .so_o(so_o),
  .irq_out_n_o(irq_out_n_o),
  .irq_out_n_oe_n_o(irq_out_n_oe_n_o),
  .subclock_out_o(subclock_out_o),
  .subclock_out_oe_n_o(subclock_out_oe_n_o)
);

// [sim/rtc_host_model.sv]
module rtc_host_model
(
  input wire logic so_i,
  output logic link_sclk_o,
  output logic ce_o,
  output logic si_o,
  output logic [7:0] rd_byte_o,
  output logic rd_tgl_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    link_sclk_o = 1'b0;
    ce_o = 1'b1;
    si_o = 1'b0;
    rd_byte_o = 8'h00;
    rd_tgl_o = 1'b0;
    // a real falling edge clears the frame logic before the first frame
    #1 ce_o = 1'b0;
  end

  // msb first; so is taken just before the rising edge that ends its bit
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si_o = tx[i];
      #15 rx[i] = so_i;
      link_sclk_o = 1'b1;
      #15 link_sclk_o = 1'b0;
    end
  endtask : shift

  task automatic frame(input logic [3:0] a, input logic rd,
    input logic [7:0] tx[$]);
    logic [7:0] rx;
    ce_o = 1'b1;
    #150 shift({a, rd, 3'h0}, rx);
    foreach (tx[k])
    begin
      shift(tx[k], rx);
      if (rd)
      begin
        rd_byte_o = rx;
        rd_tgl_o = ~rd_tgl_o;
      end
    end
    #15 ce_o = 1'b0;
    // released data line must not keep its last level
    si_o = ~si_o;
    #200;
  endtask : frame

  // clocks with chip enable low, which the device must ignore
  task automatic stray(input int n);
    repeat (n)
    begin
      si_o = 1'($urandom);
      #15 link_sclk_o = 1'b1;
      #15 link_sclk_o = 1'b0;
    end
  endtask : stray
endmodule : rtc_host_model

// [sim/tb_top.sv]
module tb_top
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i = 1'b0;
  logic srst_i = 1'b0;
  logic xtal_i = 1'b0;
  logic xtal_run = 1'b1;
  logic vdd_hi = 1'b0;
  logic vdd_lo = 1'b0;
  wire logic sclk, ce, si, so, rd_tgl, irq_od, irq_oe_n, sck_od, sck_oe_n;
  wire logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  logic [7:0] q[$];
  int failures = 0;
  int compares = 0;

  always #20 core_clk_i = ~core_clk_i;
  // timebase sped up to 2 core cycles so a whole second fits the run
  always #40 xtal_i = xtal_run ? ~xtal_i : 1'b1;

  rtc_core dut_u
  (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_en_i(1'b1),
    .xtal_i(xtal_i),
    .vdd_below_hi_i(vdd_hi),
    .vdd_below_lo_i(vdd_lo),
    .link_sclk_i(sclk),
    .ce_i(ce),
    .si_i(si),
    .so_o(so),
    .irq_out_n_o(irq_od),
    .irq_out_n_oe_n_o(irq_oe_n),
    .subclock_out_o(sck_od),
    .subclock_out_oe_n_o(sck_oe_n)
  );

  rtc_host_model host_u
  (
    .so_i(so),
    .link_sclk_o(sclk),
    .ce_o(ce),
    .si_o(si),
    .rd_byte_o(rd_byte),
    .rd_tgl_o(rd_tgl)
  );

  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    @(negedge core_clk_i);
    host_u.frame(a, 1'b0, d);
    @(negedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e[$]);
    @(negedge core_clk_i);
    foreach (e[k])
      exp_q.push_back(e[k]);
    host_u.frame(a, 1'b1, e);
    @(negedge core_clk_i);
  endtask : rd

  task automatic wait_irq(output int n);
    n = 0;
    while (irq_oe_n !== 1'b0 && n < 40000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 40000)
    begin
      failures++;
      stop_test();
    end
  endtask : wait_irq

  task automatic sck_low(input logic [7:0] e);
    int lo;
    lo = 0;
    repeat (8)
    begin
      @(negedge core_clk_i);
      lo += int'(sck_oe_n === 1'b0);
    end
    check("subclock", 8'(lo), e);
  endtask : sck_low

  initial
  begin
    #1;
    forever
    begin
      @(rd_tgl);
      check("read", rd_byte,
        exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
  end

  initial
  begin
    #3_900_000;
    failures++;
    stop_test();
  end

  initial
  begin
    logic [7:0] t, am, ah, mk;
    int n;
    n = $urandom(32'h0D67);
    // a real rising edge, so the link's handoff register leaves unknown
    #1 srst_i = 1'b1;
    idle(5);
    srst_i = 1'b0;
    idle(4);
    check("irq", 8'(irq_oe_n), 8'h01);
    q = '{8'h00, 8'h00, 8'h00, R_ZERO, R_ONE, R_ONE, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, R_CTRL1, 8'h20, 8'h00};
    rd(A_SEC, q);
    sck_low(8'h04);
    wr(A_CTRL1, '{8'h30});
    sck_low(8'h00);
    wr(A_CTRL1, '{R_CTRL1});
    t = {1'b0, 7'($urandom)};
    am = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
    ah = {4'h1, 4'($urandom % 10)};
    mk = {1'b0, 7'($urandom)};
    wr(A_TRIM, '{t, am, ah, mk, am, ah, 8'hA5});
    rd(A_TRIM, '{t, am, ah, mk, am, ah, 8'h00});
    host_u.stray(16);
    rd(A_TRIM, '{t});
    vdd_hi = 1'b1;
    idle(8);
    rd(A_CTRL2, '{8'h20});
    wr(A_CTRL2, '{8'h80});
    rd(A_CTRL2, '{8'hC0});
    vdd_hi = 1'b0;
    wr(A_CTRL2, '{8'h00});
    vdd_lo = 1'b1;
    idle(8);
    vdd_lo = 1'b0;
    idle(8);
    rd(A_CTRL2, '{8'h40});
    wr(A_CTRL2, '{8'h00});
    rd(A_CTRL2, '{8'h00});
    // 11:59:59 pm, 28 feb of a leap year, weekday 5; both alarms are
    // set for the midnight that follows, on weekday 6
    wr(A_MIN, '{8'h59, 8'h31, 8'h05, 8'h28, 8'h02, 8'h24, t, 8'h00, 8'h12,
      8'h40, 8'h00, 8'h12});
    // 12-hour mode, half-second period, alarms on, seconds written last
    wr(A_CTRL1, '{8'hC1, 8'h00, 8'h59});
    wait_irq(n);
    check("half second", 8'(n >= 32740 && n <= 32800),
      8'h01);
    rd(A_CTRL2, '{8'h04});
    wr(A_CTRL1, '{8'hC9});
    check("irq halted", 8'(irq_oe_n), 8'h01);
    wr(A_CTRL1, '{8'hC0});
    check("irq flag held", 8'(irq_oe_n), 8'h00);
    wr(A_CTRL2, '{8'h00});
    check("irq cleared", 8'(irq_oe_n), 8'h01);
    // the full second rolls minute, hour, day and weekday together
    wait_irq(n);
    rd(A_SEC, '{8'h00, 8'h00, 8'h12, 8'h06, 8'h29, 8'h02,
      8'h24});
    rd(A_CTRL2, '{8'h03});
    xtal_run = 1'b0;
    idle(2600);
    rd(A_CTRL2, '{8'h13});
    xtal_run = 1'b1;
    check("reads left", 8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule : tb_top
